//--- common/mtp_defines.svh
// timing, address and code constants of the monitor target port
`ifndef MTP_DEFINES_SVH
`define MTP_DEFINES_SVH
// ------------------------------------------------------------
// clock and bus rates
// ------------------------------------------------------------
`define MTP_CLK_HZ 200000000
`define MTP_CLK_NS 5
`define MTP_FS_HZ 400000
`define MTP_HS_HZ 2940000
// quarter bit time, rounded up so the bus never runs too fast
`define MTP_FS_QTR_CYC ((`MTP_CLK_HZ + 4*`MTP_FS_HZ - 1) / (4*`MTP_FS_HZ))
`define MTP_HS_QTR_CYC ((`MTP_CLK_HZ + 4*`MTP_HS_HZ - 1) / (4*`MTP_HS_HZ))
// ------------------------------------------------------------
// spike suppression, longest pulse rejected, rounded down
// ------------------------------------------------------------
`define MTP_FS_SPIKE_NS 50
`define MTP_HS_SPIKE_NS 10
`define MTP_FS_SPIKE_CYC (`MTP_FS_SPIKE_NS / `MTP_CLK_NS)
`define MTP_HS_SPIKE_CYC (`MTP_HS_SPIKE_NS / `MTP_CLK_NS)
// ------------------------------------------------------------
// addresses and codes
// ------------------------------------------------------------
`define MTP_ADDR_BASE 3'h4
`define MTP_GC_ADDR 7'h00
`define MTP_GC_RESET 8'h06
`define MTP_ARA_ADDR 7'h0C
`define MTP_HS_CODE 5'h01
`define MTP_HS_BYTE 8'h08
`define MTP_PTR_RST 8'h00
`define MTP_LINES_IDLE 2'h3
`endif

//--- common/mtp_if.sv
// open-drain two-wire bus joining controller and target
`timescale 1ns/10ps
interface mtp_if;
	logic ctl_scl_oe;   // controller pulls clock low
	logic ctl_sda_oe;   // controller pulls data low
	logic tgt_sda_oe;   // target pulls data low
	logic tgt_alert_oe; // target pulls alert low
	logic scl;          // resolved clock line
	logic sda;          // resolved data line
	logic alert_b;      // resolved alert line, low active
	// wired-and of all pull-downs against the pull-ups
	assign scl     = ~ctl_scl_oe;
	assign sda     = ~(ctl_sda_oe | tgt_sda_oe);
	assign alert_b = ~tgt_alert_oe;
	modport target (input scl, input sda, output tgt_sda_oe,
		output tgt_alert_oe);
	modport controller (input scl, input sda, input alert_b,
		output ctl_scl_oe, output ctl_sda_oe);
endinterface : mtp_if

//--- common/mtp_pkg.sv
// types shared by both ends of the monitor target port
package mtp_pkg;
	// strap connection code: ground, supply, data line, clock line
	typedef enum logic [1:0] {MTP_GND, MTP_SUPPLY, MTP_TO_SDA, MTP_TO_SCL}
		mtp_strap_t;
	// target bit-level states
	typedef enum logic [2:0] {T_IDLE, T_RX, T_ACK, T_TX, T_TXACK, T_IGN}
		mtp_tst_t;
	// which byte of a transaction the target is in
	typedef enum logic [2:0] {PH_ADDR, PH_PTR, PH_WHI, PH_WLO, PH_DONE,
		PH_GC, PH_RHI, PH_ARA} mtp_phase_t;
	// controller states
	typedef enum logic [2:0] {C_IDLE, C_START, C_WBIT, C_RBIT, C_STOP}
		mtp_cst_t;
	// controller commands
	typedef enum logic [2:0] {MTP_CMD_WRITE, MTP_CMD_SETPTR, MTP_CMD_READ,
		MTP_CMD_GCRST, MTP_CMD_ARA, MTP_CMD_HS} mtp_cmd_t;
	// whole target state
	typedef struct packed {
		mtp_tst_t        st;
		mtp_phase_t      ph;
		logic [1:0]      s1;
		logic [1:0]      s2;
		logic [1:0]      filt;
		logic [1:0][3:0] fcnt;
		logic [3:0]      p1;
		logic [3:0]      p2;
		logic [3:0]      cnt;
		logic [7:0]      sh;
		logic [15:0]     txd;
		logic [6:0]      own;
		logic [7:0]      ptr;
		logic [7:0]      whi;
		logic [15:0]     wdat;
		logic            mack;
		logic            hs;
		logic            alert;
		logic            sda_oe;
		logic            wr;
		logic            rd;
		logic            srst;
	} mtp_tgt_state_t;
	// whole controller state
	typedef struct packed {
		mtp_cst_t    st;
		mtp_cmd_t    kind;
		logic [1:0]  q;
		logic [7:0]  div;
		logic [3:0]  cnt;
		logic [2:0]  nw;
		logic [1:0]  nr;
		logic [31:0] bytes;
		logic [7:0]  sh;
		logic [15:0] rd;
		logic [1:0]  s1;
		logic [1:0]  s2;
		logic        nak;
		logic        hold;
		logic        scl_oe;
		logic        sda_oe;
		logic        hs;
		logic        rdy;
		logic        rsp_valid;
		logic        rsp_nack;
		logic        alert_seen;
	} mtp_ctl_state_t;
endpackage : mtp_pkg

//--- verif/mtp_checker.sv
// wire-level checker for the monitor target port
`timescale 1ns/10ps
module mtp_checker
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ctl_scl_oe,
	input wire logic ctl_sda_oe,
	input wire logic tgt_sda_oe,
	input wire logic tgt_alert_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic alert_b
);
	// ------------------------------------------------------------
	// byte tracking
	// ------------------------------------------------------------
	logic       scl_q;  // clock line one cycle ago
	logic       sda_q;  // data line one cycle ago
	logic [3:0] cnt;    // bits seen in this byte
	logic [2:0] bidx;   // bytes since start
	logic [7:0] sh;     // bits shifted in
	logic [7:0] a0;     // address byte
	logic       a0_ack; // address byte acknowledged
	logic       rel_ok; // alert release allowed
	logic       rise;   // clock line rising
	logic       slot;   // acknowledge bit sampled
	assign rise = scl & ~scl_q;
	assign slot = rise & (cnt == 4'h8);
	// follow bytes; a start or stop restarts the count
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			cnt    <= 4'h0;
			bidx   <= 3'h0;
			sh     <= 8'h00;
			a0     <= 8'h00;
			a0_ack <= 1'b0;
			rel_ok <= 1'b0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl & scl_q & (sda != sda_q))
			begin
				cnt    <= 4'h0;
				bidx   <= 3'h0;
				rel_ok <= 1'b0;
			end
			else if (slot)
			begin
				cnt <= 4'h0;
				if (bidx != 3'h7)
					bidx <= bidx + 3'h1;
				if (bidx == 3'h0)
				begin
					a0     <= sh;
					a0_ack <= ~sda;
					rel_ok <= ~sda & ((sh == 8'h19) | (sh == 8'h00));
				end
			end
			else if (rise)
			begin
				cnt <= cnt + 4'h1;
				sh  <= {sh[6:0], sda};
			end
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	a_tgt_low_edges: assert property ($changed(tgt_sda_oe) |-> !scl)
		else $error("target data pull moved with clock high");
	a_ctl_read_free: assert property (rise && cnt < 4'h8
		&& (bidx == 3'h1 || (bidx == 3'h2 && a0 != 8'h19))
		&& a0[0] && a0_ack |-> !ctl_sda_oe)
		else $error("controller drove data during read byte");
	a_hs_code_nak: assert property (slot && bidx == 3'h0
		&& sh[7:3] == 5'h01 |-> !tgt_sda_oe)
		else $error("speed code acknowledged");
	a_gc_addr_ack: assert property (slot && bidx == 3'h0 && sh == 8'h00
		|-> tgt_sda_oe)
		else $error("general call not acknowledged");
	a_gc_data_ack: assert property (slot && bidx == 3'h1 && a0 == 8'h00
		|-> tgt_sda_oe == (sh == 8'h06))
		else $error("general call data acknowledge wrong");
	a_ara_ack_alert: assert property (slot && bidx == 3'h0 && sh == 8'h19
		|-> tgt_sda_oe == tgt_alert_oe)
		else $error("alert response acknowledge wrong");
	a_ara_reply_form: assert property (slot && bidx == 3'h1
		&& a0 == 8'h19 && a0_ack |-> sh[7:5] == 3'h4 && !sh[0])
		else $error("alert reply byte malformed");
	a_alert_hold: assert property ($fell(tgt_alert_oe) |-> rel_ok)
		else $error("alert released without alert response");
	a_nak_silent: assert property (bidx != 3'h0 && !a0_ack |-> !tgt_sda_oe)
		else $error("target drove data after address refused");
	a_write_acked: assert property (slot && bidx >= 3'h1 && bidx <= 3'h3
		&& a0_ack && !a0[0] && a0 != 8'h00 |-> tgt_sda_oe)
		else $error("write byte not acknowledged");
endmodule : mtp_checker

//--- verif/tb.sv
// self-checking bench joining controller and target ends
`timescale 1ns/10ps
module tb import mtp_pkg::*;
;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        clk;        // 200 MHz clock
	logic        rst_b;      // reset, low active
	logic        cmd_valid;  // command request
	mtp_cmd_t    cmd_kind;   // command code
	logic [6:0]  cmd_addr;   // target address
	logic [7:0]  cmd_ptr;    // pointer byte
	logic [15:0] cmd_wdata;  // write word
	logic        cmd_hold;   // keep bus, no stop
	logic        cmd_ready;  // controller idle
	logic        rsp_valid;  // command finished
	logic [15:0] rsp_data;   // read word
	logic        rsp_nack;   // byte refused
	logic        alert_seen; // alert line low
	logic        ctl_hs;     // controller high speed
	mtp_strap_t  strap_lo;   // low strap
	mtp_strap_t  strap_hi;   // high strap
	logic        alert_req;  // monitor alert
	logic [15:0] reg_rdata;  // word at pointer
	logic [7:0]  reg_ptr;    // register pointer
	logic        reg_wr;     // write pulse
	logic [15:0] reg_wdata;  // written word
	logic        reg_rd;     // read sample pulse
	logic        soft_rst;   // soft reset pulse
	logic        tgt_hs;     // target high speed
	logic [15:0] wr_word;    // last word written
	logic [6:0]  own;        // expected own address
	int          n_errors = 0; // mismatches
	int          compares = 0; // comparisons
	int          n_wr = 0;   // write pulses
	int          n_rd = 0;   // read pulses
	int          n_srst = 0; // soft reset pulses
	// ------------------------------------------------------------
	// design and checker
	// ------------------------------------------------------------
	mtp_if bus ();
	mtp_controller mtp_controller_i (.clk(clk), .rst_b(rst_b), .bus(bus),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
		.cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata), .cmd_hold(cmd_hold),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack), .alert_seen(alert_seen), .hs_mode(ctl_hs));
	mtp_target mtp_target_i (.clk(clk), .rst_b(rst_b), .bus(bus),
		.addr_strap_low(strap_lo), .addr_strap_high(strap_hi),
		.alert_req(alert_req), .reg_rdata(reg_rdata), .reg_ptr(reg_ptr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.soft_rst(soft_rst), .hs_mode(tgt_hs));
	mtp_checker mtp_checker_i (.clk(clk), .rst_b(rst_b),
		.ctl_scl_oe(bus.ctl_scl_oe), .ctl_sda_oe(bus.ctl_sda_oe),
		.tgt_sda_oe(bus.tgt_sda_oe), .tgt_alert_oe(bus.tgt_alert_oe),
		.scl(bus.scl), .sda(bus.sda), .alert_b(bus.alert_b));
	// register file stand-in: pointer and its inverse
	assign reg_rdata = {reg_ptr, ~reg_ptr};
	// clock
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	// count user-side pulses, sampled away from the launching edge
	always @(negedge clk)
	begin
		if (reg_wr === 1'b1)
		begin
			n_wr++;
			wr_word = reg_wdata;
		end
		if (reg_rd === 1'b1)
			n_rd++;
		if (soft_rst === 1'b1)
			n_srst++;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task automatic check16(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check16
	// wait for ready (0) or response (1), bounded
	task automatic wait_flag(input bit for_rsp, input int lim);
		int i;
		i = 0;
		while ((for_rsp ? rsp_valid : cmd_ready) !== 1'b1 && i < lim)
		begin
			@(negedge clk);
			i++;
		end
		if (i >= lim)
		begin
			n_errors++;
			$display("Error handshake expected 1 seen timeout");
			complete_run();
		end
	endtask : wait_flag
	// one controller command, whole
	task automatic run(input mtp_cmd_t k, input logic [6:0] a,
		input logic [7:0] p, input logic [15:0] d, input logic h);
		wait_flag(1'b0, 100);
		cmd_kind  = k;
		cmd_addr  = a;
		cmd_ptr   = p;
		cmd_wdata = d;
		cmd_hold  = h;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		wait_flag(1'b1, 40000);
	endtask : run
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_kind = MTP_CMD_WRITE;
		cmd_addr = 7'h00;
		cmd_ptr = 8'h00;
		cmd_wdata = 16'h0000;
		cmd_hold = 1'b0;
		strap_lo = MTP_TO_SDA;
		strap_hi = MTP_SUPPLY;
		alert_req = 1'b0;
		own = 7'h46;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		check16("reset pointer", 16'h0000, 16'(reg_ptr));
		run(MTP_CMD_HS, 7'h00, 8'h00, 16'h0000, 1'b1);
		check16("target speed", 16'h0001, 16'(tgt_hs));
		check16("controller speed", 16'h0001, 16'(ctl_hs));
		run(MTP_CMD_WRITE, own, 8'h05, 16'hA5C3, 1'b1);
		check16("write nack", 16'h0000, 16'(rsp_nack));
		check16("write pulses", 16'h0001, 16'(n_wr));
		check16("written word", 16'hA5C3, wr_word);
		check16("pointer", 16'h0005, 16'(reg_ptr));
		check16("speed kept", 16'h0001, 16'(tgt_hs));
		for (int r = 1; r <= 2; r++)
		begin
			run(MTP_CMD_READ, own, 8'h00, 16'h0000, 1'b1);
			check16("read word", 16'h05FA, rsp_data);
			check16("pointer kept", 16'h0005, 16'(reg_ptr));
			check16("read samples", 16'(r), 16'(n_rd));
		end
		run(MTP_CMD_WRITE, own ^ 7'h01, 8'h33, 16'h1111, 1'b1);
		check16("foreign nack", 16'h0001, 16'(rsp_nack));
		check16("foreign writes", 16'h0001, 16'(n_wr));
		check16("foreign pointer", 16'h0005, 16'(reg_ptr));
		for (int c = 0; c < 4; c++)
		begin
			strap_hi = mtp_strap_t'(c);
			strap_lo = mtp_strap_t'(3 - c);
			own = {3'h4, 2'(c), 2'(3 - c)};
			run(MTP_CMD_SETPTR, own, 8'(8'h10 + c), 16'h0000, 1'b1);
			check16("strap nack", 16'h0000, 16'(rsp_nack));
			check16("strap pointer", 16'(8'h10 + c), 16'(reg_ptr));
		end
		alert_req = 1'b1;
		repeat (2) @(negedge clk);
		alert_req = 1'b0;
		repeat (6) @(negedge clk);
		check16("alert raised", 16'h0001, 16'(alert_seen));
		run(MTP_CMD_ARA, 7'h00, 8'h00, 16'h0000, 1'b1);
		check16("alert reply", 16'({own, 1'b0}), 16'(rsp_data[7:0]));
		repeat (6) @(negedge clk);
		check16("alert cleared", 16'h0000, 16'(alert_seen));
		run(MTP_CMD_ARA, 7'h00, 8'h00, 16'h0000, 1'b1);
		check16("quiet alert nack", 16'h0001, 16'(rsp_nack));
		run(MTP_CMD_GCRST, 7'h00, 8'h00, 16'h0000, 1'b0);
		check16("soft resets", 16'h0001, 16'(n_srst));
		check16("pointer cleared", 16'h0000, 16'(reg_ptr));
		check16("speed after stop", 16'h0000, 16'(tgt_hs));
		check16("controller slow", 16'h0000, 16'(ctl_hs));
		run(MTP_CMD_READ, own, 8'h00, 16'h0000, 1'b0);
		check16("fast read word", 16'h00FF, rsp_data);
		complete_run();
	end
endmodule : tb

//--- verilog/mtp_controller.sv
// bus controller end of the monitor target port
`timescale 1ns/10ps
`include "mtp_defines.svh"
module mtp_controller import mtp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	mtp_if.controller       bus,
	input  wire logic       cmd_valid,
	input  wire mtp_cmd_t   cmd_kind,
	input  wire logic [6:0] cmd_addr,
	input  wire logic [7:0] cmd_ptr,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic       cmd_hold,
	output logic            cmd_ready,
	output logic            rsp_valid,
	output logic [15:0]     rsp_data,
	output logic            rsp_nack,
	output logic            alert_seen,
	output logic            hs_mode
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	mtp_ctl_state_t r;   // registered state
	mtp_ctl_state_t n;   // next state
	logic           tick; // quarter bit enable
	logic           fin;  // last bit of the command done
	logic [7:0]     lim;  // quarter length in cycles

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = r;
		fin = 1'b0;
		n.rsp_valid = 1'b0;
		n.s1 = {bus.alert_b, bus.sda};
		n.s2 = r.s1;
		n.alert_seen = ~r.s2[1];
		// fast rate until the speed code went out
		lim = r.hs ? 8'(`MTP_HS_QTR_CYC) : 8'(`MTP_FS_QTR_CYC);
		tick = (r.div == 8'h00);
		n.div = tick ? lim - 8'h01 : r.div - 8'h01;
		if (tick && r.st != C_IDLE)
			n.q = r.q + 2'h1;
		case (r.st)
		C_IDLE:
			if (cmd_valid && r.rdy)
			begin
				// every command opens with its address byte, the speed command with the speed code
				n.kind = cmd_kind;
				n.nak = 1'b0;
				n.rsp_nack = 1'b0;
				n.hold = cmd_hold;
				n.q = 2'h0;
				n.div = lim - 8'h01;
				n.cnt = 4'h0;
				n.nr = 2'h0;
				n.nw = 3'h2;
				n.st = C_START;
				case (cmd_kind)
				MTP_CMD_WRITE:
				begin
					n.bytes = {cmd_addr, 1'b0, cmd_ptr, cmd_wdata};
					n.nw = 3'h4;
				end
				MTP_CMD_SETPTR:
					n.bytes = {cmd_addr, 1'b0, cmd_ptr, 16'h0000};
				MTP_CMD_READ:
				begin
					n.bytes = {cmd_addr, 1'b1, 24'h000000};
					n.nw = 3'h1;
					n.nr = 2'h2;
				end
				MTP_CMD_GCRST:
					n.bytes = {`MTP_GC_ADDR, 1'b0, `MTP_GC_RESET, 16'h0000};
				MTP_CMD_ARA:
				begin
					n.bytes = {`MTP_ARA_ADDR, 1'b1, 24'h000000};
					n.nw = 3'h1;
					n.nr = 2'h1;
				end
				MTP_CMD_HS:
				begin
					n.bytes = {`MTP_HS_BYTE, 24'h000000};
					n.nw = 3'h1;
				end
				default:
					n.st = C_IDLE;
				endcase
				n.sh = n.bytes[31:24];
			end
		C_START:
			// release data, release clock, data low, clock low
			if (tick)
				case (r.q)
				2'h0: n.sda_oe = 1'b0;
				2'h1: n.scl_oe = 1'b0;
				2'h2: n.sda_oe = 1'b1;
				default:
				begin
					n.scl_oe = 1'b1;
					n.bytes = r.bytes << 8;
					n.st = C_WBIT;
				end
				endcase
		C_WBIT:
			if (tick)
				case (r.q)
				2'h0: n.sda_oe = (r.cnt != 4'h8) && !r.sh[7];
				2'h1: n.scl_oe = 1'b0;
				2'h2:
					if (r.cnt == 4'h8)
						n.nak = r.s2[0];
					else
						n.sh = {r.sh[6:0], 1'b0};
				default:
				begin
					n.scl_oe = 1'b1;
					n.cnt = r.cnt + 4'h1;
					if (r.cnt == 4'h8)
					begin
						n.cnt = 4'h0;
						n.nw = r.nw - 3'h1;
						// the speed code is never acknowledged
						if (r.nak && r.kind != MTP_CMD_HS)
						begin
							n.rsp_nack = 1'b1;
							n.st = C_STOP;
						end
						else if (r.nak || (r.nw == 3'h1 && r.nr == 2'h0))
							fin = 1'b1;
						else if (r.nw != 3'h1)
						begin
							n.sh = r.bytes[31:24];
							n.bytes = r.bytes << 8;
						end
						else
							n.st = C_RBIT;
					end
				end
				endcase
		C_RBIT:
			if (tick)
				case (r.q)
				// acknowledge the high byte, refuse the last one
				2'h0: n.sda_oe = (r.cnt == 4'h8) && (r.nr != 2'h1);
				2'h1: n.scl_oe = 1'b0;
				2'h2:
					if (r.cnt != 4'h8)
						n.rd = {r.rd[14:0], r.s2[0]};
				default:
				begin
					n.scl_oe = 1'b1;
					n.cnt = r.cnt + 4'h1;
					if (r.cnt == 4'h8)
					begin
						n.cnt = 4'h0;
						n.nr = r.nr - 2'h1;
						fin = (r.nr == 2'h1);
					end
				end
				endcase
		C_STOP:
			// data low, release clock, release data
			if (tick)
				case (r.q)
				2'h0: n.sda_oe = 1'b1;
				2'h1: n.scl_oe = 1'b0;
				2'h2: n.sda_oe = 1'b0;
				default:
				begin
					n.hs = 1'b0;
					n.rsp_valid = 1'b1;
					n.st = C_IDLE;
				end
				endcase
		default:
			n.st = C_IDLE;
		endcase
		// end with a stop, or keep the bus for a repeated start
		if (fin)
		begin
			if (r.hold || r.kind == MTP_CMD_HS)
			begin
				n.sda_oe = 1'b0;
				n.rsp_valid = 1'b1;
				n.hs = r.hs || (r.kind == MTP_CMD_HS);
				n.st = C_IDLE;
			end
			else
				n.st = C_STOP;
		end
		n.rdy = (n.st == C_IDLE);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			r <= '0;
			r.s1 <= `MTP_LINES_IDLE;
			r.s2 <= `MTP_LINES_IDLE;
		end
		else
			r <= n;
	end

	assign bus.ctl_scl_oe = r.scl_oe;
	assign bus.ctl_sda_oe = r.sda_oe;
	assign cmd_ready      = r.rdy;
	assign rsp_valid      = r.rsp_valid;
	assign rsp_data       = r.rd;
	assign rsp_nack       = r.rsp_nack;
	assign alert_seen     = r.alert_seen;
	assign hs_mode        = r.hs;
endmodule : mtp_controller

//--- verilog/mtp_target.sv
// two-wire target end of the monitor target port
`timescale 1ns/10ps
`include "mtp_defines.svh"
// ------------------------------------------------------------
// Summary of operation
// - target only, open-drain data, clock untouched
// - fast rate to 400kHz, high speed 2.94MHz
// - both lines filtered against short spikes
// - each transaction opens with address byte
// - address is 100, high strap, low strap
// - straps resampled at every start
// - straps settled before any bus traffic
// - first written byte loads the pointer
// - acknowledge address, pointer, data; store word
// - controller ends writes by stop or start
// - read returns register at last pointer
// - high byte, controller ack, low byte
// - reads never move the pointer
// - no clock stretching, no error check bytes
// - speed code recognised, not acknowledged
// - high speed kept until a stop
// - general call 06 gives soft reset
// - alert response returns own address
// - lost arbitration: no ack, alert held
// - alert output open-drain, low active
// ------------------------------------------------------------
module mtp_target import mtp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	mtp_if.target           bus,
	input  wire mtp_strap_t addr_strap_low,
	input  wire mtp_strap_t addr_strap_high,
	input  wire logic       alert_req,
	input  wire logic [15:0] reg_rdata,
	output logic [7:0]      reg_ptr,
	output logic            reg_wr,
	output logic [15:0]     reg_wdata,
	output logic            reg_rd,
	output logic            soft_rst,
	output logic            hs_mode
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	mtp_tgt_state_t r;     // registered state
	mtp_tgt_state_t n;     // next state
	logic [3:0]     lim;   // spike filter length
	logic           rise;  // filtered clock rose
	logic           fall;  // filtered clock fell
	logic           start; // start or repeated start
	logic           stop;  // stop condition
	logic           ack;   // acknowledge the byte just taken
	logic           won;   // alert response byte fully sent
	mtp_phase_t     nph;   // phase after the acknowledge

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = r;
		ack = 1'b0;
		won = 1'b0;
		nph = r.ph;
		n.wr = 1'b0;
		n.rd = 1'b0;
		n.srst = 1'b0;
		// two flops on both bus lines and the straps before any logic
		n.s1 = {bus.sda, bus.scl};
		n.s2 = r.s1;
		n.p1 = {addr_strap_high, addr_strap_low};
		n.p2 = r.p1;
		// shorter filter once high speed is entered
		lim = r.hs ? 4'(`MTP_HS_SPIKE_CYC) : 4'(`MTP_FS_SPIKE_CYC);
		// a level must hold lim cycles before it is believed
		for (int i = 0; i < 2; i++)
		begin
			if (r.s2[i] == r.filt[i])
				n.fcnt[i] = 4'h0;
			else if (r.fcnt[i] == lim - 4'h1)
			begin
				n.filt[i] = r.s2[i];
				n.fcnt[i] = 4'h0;
			end
			else
				n.fcnt[i] = r.fcnt[i] + 4'h1;
		end
		rise = n.filt[0] & ~r.filt[0];
		fall = ~n.filt[0] & r.filt[0];
		start = n.filt[0] & r.filt[0] & r.filt[1] & ~n.filt[1];
		stop = n.filt[0] & r.filt[0] & ~r.filt[1] & n.filt[1];
		if (start)
		begin
			// straps are read afresh for each transaction
			n.own = {`MTP_ADDR_BASE, r.p2};
			n.st = T_RX;
			n.ph = PH_ADDR;
			n.cnt = 4'h0;
			n.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			n.hs = 1'b0;
			n.sda_oe = 1'b0;
			n.st = T_IDLE;
		end
		else
			case (r.st)
			T_RX:
				if (rise && r.cnt != 4'h8)
				begin
					n.sh = {r.sh[6:0], n.filt[1]};
					n.cnt = r.cnt + 4'h1;
				end
				else if (fall && r.cnt == 4'h8)
				begin
					case (r.ph)
					PH_ADDR:
						if (r.sh[7:1] == r.own)
						begin
							ack = 1'b1;
							nph = r.sh[0] ? PH_RHI : PH_PTR;
							if (r.sh[0])
							begin
								// both bytes from one sample
								n.txd = reg_rdata;
								n.rd = 1'b1;
							end
						end
						else if (r.sh[7:3] == `MTP_HS_CODE)
							n.hs = 1'b1;
						else if (r.sh == {`MTP_GC_ADDR, 1'b0})
						begin
							ack = 1'b1;
							nph = PH_GC;
						end
						else if (r.sh == {`MTP_ARA_ADDR, 1'b1} && r.alert)
						begin
							ack = 1'b1;
							nph = PH_ARA;
							n.txd = {r.own, 1'b0, 8'h00};
						end
					PH_PTR:
					begin
						ack = 1'b1;
						n.ptr = r.sh;
						nph = PH_WHI;
					end
					PH_WHI:
					begin
						ack = 1'b1;
						n.whi = r.sh;
						nph = PH_WLO;
					end
					PH_WLO:
					begin
						// high byte first, stored as one word
						ack = 1'b1;
						n.wdat = {r.whi, r.sh};
						n.wr = 1'b1;
						nph = PH_DONE;
					end
					PH_GC:
						if (r.sh == `MTP_GC_RESET)
						begin
							ack = 1'b1;
							n.srst = 1'b1;
							n.ptr = `MTP_PTR_RST;
							nph = PH_DONE;
						end
					default:
						ack = 1'b0;
					endcase
					// refused bytes leave data released until next start
					n.st = ack ? T_ACK : T_IGN;
					n.sda_oe = ack;
					n.ph = nph;
				end
			T_ACK:
				if (fall)
				begin
					n.sda_oe = 1'b0;
					n.cnt = 4'h0;
					n.st = T_RX;
					if (r.ph == PH_RHI || r.ph == PH_ARA)
					begin
						n.st = T_TX;
						n.sda_oe = ~r.txd[15];
						n.txd = {r.txd[14:0], 1'b0};
						n.cnt = 4'h1;
					end
				end
			T_TX:
				// released bit seen low: another target won
				if (rise && !r.sda_oe && !n.filt[1])
					n.st = T_IGN;
				else if (fall && r.cnt == 4'h8)
				begin
					n.sda_oe = 1'b0;
					n.st = T_TXACK;
					won = (r.ph == PH_ARA);
				end
				else if (fall)
				begin
					n.sda_oe = ~r.txd[15];
					n.txd = {r.txd[14:0], 1'b0};
					n.cnt = r.cnt + 4'h1;
				end
			T_TXACK:
				if (rise)
					n.mack = ~n.filt[1];
				else if (fall)
				begin
					n.st = T_IGN;
					// low byte only after the controller acknowledged
					if (r.ph == PH_RHI && r.mack)
					begin
						n.st = T_TX;
						n.ph = PH_DONE;
						n.sda_oe = ~r.txd[15];
						n.txd = {r.txd[14:0], 1'b0};
						n.cnt = 4'h1;
					end
				end
			T_IGN:
				n.sda_oe = 1'b0;
			default:
				n.st = T_IDLE;
			endcase
		// alert stays latched until an alert response is won
		n.alert = alert_req | (r.alert & ~won);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			r <= '0;
			r.s1 <= `MTP_LINES_IDLE;
			r.s2 <= `MTP_LINES_IDLE;
			r.filt <= `MTP_LINES_IDLE;
		end
		else
			r <= n;
	end

	// ------------------------------------------------------------
	// outputs; the clock line is never driven
	// ------------------------------------------------------------
	assign bus.tgt_sda_oe   = r.sda_oe;
	assign bus.tgt_alert_oe = r.alert;
	assign reg_ptr          = r.ptr;
	assign reg_wr           = r.wr;
	assign reg_wdata        = r.wdat;
	assign reg_rd           = r.rd;
	assign soft_rst         = r.srst;
	assign hs_mode          = r.hs;
endmodule : mtp_target
